/* hw/dmir_params.svh */
/*
 Constants for the module identification readback block: command codes,
 fixed byte values and reset values.
 Assumes it is included once by each design file that needs it.
*/
// Contract
// - First byte after ID command is dummy
// - Command DA returns first identification byte second
// - Commands DB, DC return second, third bytes
// - ID commands answered in every operating state
// - ID bytes fixed across every kind of reset
`ifndef DMIR_PARAMS_SVH
`define DMIR_PARAMS_SVH

`define DMIR_CMD_IDENT_FIRST 8'hda
`define DMIR_CMD_IDENT_SECOND 8'hdb
`define DMIR_CMD_IDENT_THIRD 8'hdc
`define DMIR_DUMMY_BYTE 8'h00
`define DMIR_DATA_RESET 8'h00
`define DMIR_STROBE_IDLE 2'h3
`define DMIR_BUS_IDLE 9'h000

`endif

/* hw/dmir_pkg.sv */
/*
 Types for the module identification readback block.
 Assumes nothing of its surroundings.
*/
package dmir_pkg;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_dummy = 3'b010,
		st_ident = 3'b100
	} dmir_state_t;

	typedef enum logic [1:0] {
		sel_first = 2'h0,
		sel_second = 2'h1,
		sel_third = 2'h2
	} dmir_sel_t;

endpackage : dmir_pkg

/* hw/dmir_sync.sv */
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the inputs are levels that stay put for several clock periods.
*/
`timescale 1ns/100ps
module dmir_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Pin side and synchronised side.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = d;
		q_d = meta_q;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= meta_d;
			q <= q_d;
		end
	end

endmodule : dmir_sync

/* hw/dmir_top.sv */
/*
 Identification readback for the host command port of a display driver.
 A write strobe with the select low carries a command byte; the three
 identification read commands arm a two-byte readback: a dummy byte and
 then the chosen identification byte, each driven while the read strobe
 is low. Any other command disarms the readback.
 Assumes the host pins are asynchronous to sys_clk and that each strobe
 level and the bus data stay put for at least five clock periods.
*/
`timescale 1ns/100ps
`include "dmir_params.svh"
module dmir_top
	import dmir_pkg::*;
#(
	// Identification byte values; the defaults are arbitrary.
	parameter logic [7:0] IDENT_BYTE_FIRST = 8'h5a,
	parameter logic [7:0] IDENT_BYTE_SECOND = 8'h6b,
	parameter logic [7:0] IDENT_BYTE_THIRD = 8'h7c
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Host strobes and select.
	input wire logic data_command_select,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	// Host data bus, split into its three signals.
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n
);
	logic [1:0] strobe_s;
	logic [8:0] bus_s;
	logic rd_n_s;
	logic wr_n_s;
	logic dc_sel_s;
	logic [7:0] din_s;
	logic rd_n_prev_q;
	logic wr_n_prev_q;
	logic rd_fall;
	logic rd_rise;
	logic wr_rise;
	logic cmd_write;

	dmir_sync #(
		.W(2),
		.RST(`DMIR_STROBE_IDLE)
	) u_sync_strobe (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({read_strobe_n, write_strobe_n}),
		.q(strobe_s)
	);

	dmir_sync #(
		.W(9),
		.RST(`DMIR_BUS_IDLE)
	) u_sync_bus (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d({data_command_select, data_in}),
		.q(bus_s)
	);

	assign rd_n_s = strobe_s[1];
	assign wr_n_s = strobe_s[0];
	assign dc_sel_s = bus_s[8];
	assign din_s = bus_s[7:0];

	// Edge detection on the synchronised strobes.
	logic rd_n_prev_d;
	logic wr_n_prev_d;

	always_comb begin
		rd_n_prev_d = rd_n_s;
		wr_n_prev_d = wr_n_s;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_n_prev_q <= 1'b1;
			wr_n_prev_q <= 1'b1;
		end else begin
			rd_n_prev_q <= rd_n_prev_d;
			wr_n_prev_q <= wr_n_prev_d;
		end
	end

	assign rd_fall = rd_n_prev_q & ~rd_n_s;
	assign rd_rise = ~rd_n_prev_q & rd_n_s;
	assign wr_rise = ~wr_n_prev_q & wr_n_s;
	assign cmd_write = wr_rise & ~dc_sel_s;

	// Readback sequencer. No power mode gates it, so the commands are
	// answered in sleep, idle, partial and normal alike.
	dmir_state_t state_q;
	dmir_state_t state_d;
	dmir_sel_t sel_q;
	dmir_sel_t sel_d;
	logic [7:0] ident_byte;

	always_comb begin
		case (sel_q)
			sel_first: ident_byte = IDENT_BYTE_FIRST;
			sel_second: ident_byte = IDENT_BYTE_SECOND;
			sel_third: ident_byte = IDENT_BYTE_THIRD;
			default: ident_byte = IDENT_BYTE_FIRST;
		endcase
	end

	always_comb begin
		state_d = state_q;
		sel_d = sel_q;
		if (cmd_write) begin
			case (din_s)
				`DMIR_CMD_IDENT_FIRST: begin
					state_d = st_dummy;
					sel_d = sel_first;
				end
				`DMIR_CMD_IDENT_SECOND: begin
					state_d = st_dummy;
					sel_d = sel_second;
				end
				`DMIR_CMD_IDENT_THIRD: begin
					state_d = st_dummy;
					sel_d = sel_third;
				end
				default: begin
					state_d = st_idle;
				end
			endcase
		end else if (rd_rise) begin
			case (state_q)
				st_dummy: state_d = st_ident;
				st_ident: state_d = st_idle;
				st_idle: state_d = st_idle;
				default: state_d = st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= st_idle;
			sel_q <= sel_first;
		end else begin
			state_q <= state_d;
			sel_q <= sel_d;
		end
	end

	// Bus driver. Data is loaded at a read falling edge in st_dummy or st_ident and held,
	// with the enable low, until the read strobe returns high.
	logic [7:0] data_d;
	logic oe_n_d;

	always_comb begin
		data_d = data_out;
		oe_n_d = data_oe_n;
		if (rd_fall) begin
			case (state_q)
				st_dummy: begin
					data_d = `DMIR_DUMMY_BYTE;
					oe_n_d = 1'b0;
				end
				st_ident: begin
					data_d = ident_byte;
					oe_n_d = 1'b0;
				end
				st_idle: oe_n_d = 1'b1;
				default: oe_n_d = 1'b1;
			endcase
		end else if (rd_n_s) begin
			oe_n_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_out <= `DMIR_DATA_RESET;
			data_oe_n <= 1'b1;
		end else begin
			data_out <= data_d;
			data_oe_n <= oe_n_d;
		end
	end

	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_dummy_first;
		state_q == st_dummy && rd_fall |=>
			data_out == `DMIR_DUMMY_BYTE && !data_oe_n;
	endproperty
	a_dummy_first: assert property (p_dummy_first)
		else $error("dummy byte not driven on first read");

	property p_ident_first;
		state_q == st_ident && sel_q == sel_first && rd_fall |=>
			data_out == IDENT_BYTE_FIRST && !data_oe_n;
	endproperty
	a_ident_first: assert property (p_ident_first)
		else $error("first identification byte wrong");

	property p_ident_other;
		state_q == st_ident && sel_q != sel_first && rd_fall |=>
			data_out == (sel_q == sel_second ? IDENT_BYTE_SECOND :
			IDENT_BYTE_THIRD) && !data_oe_n;
	endproperty
	a_ident_other: assert property (p_ident_other)
		else $error("second or third identification byte wrong");

	property p_accept_any;
		cmd_write && (din_s == `DMIR_CMD_IDENT_FIRST ||
			din_s == `DMIR_CMD_IDENT_SECOND ||
			din_s == `DMIR_CMD_IDENT_THIRD) |=> state_q == st_dummy;
	endproperty
	a_accept_any: assert property (p_accept_any)
		else $error("identification command not accepted");

	property p_dummy_then_ident;
		state_q == st_dummy && rd_rise && !cmd_write |=>
			state_q == st_ident ##0 $stable(sel_q);
	endproperty
	a_dummy_then_ident: assert property (p_dummy_then_ident)
		else $error("readback did not advance past dummy");

	property p_fixed_value;
		$fell(data_oe_n) && state_q == st_ident |->
			$past(sel_q) == sel_q && data_out ==
			(sel_q == sel_first ? IDENT_BYTE_FIRST :
			sel_q == sel_second ? IDENT_BYTE_SECOND :
			IDENT_BYTE_THIRD);
	endproperty
	a_fixed_value: assert property (p_fixed_value)
		else $error("identification byte not the fixed value");

	property p_release;
		!data_oe_n && rd_n_s |=> data_oe_n;
	endproperty
	a_release: assert property (p_release)
		else $error("bus still driven after read strobe rose");

	c_first: cover property (state_q == st_ident && sel_q == sel_first
		&& rd_fall);
	c_third: cover property (state_q == st_ident && sel_q == sel_third
		&& rd_fall);
	c_abort: cover property (state_q == st_dummy && cmd_write
		&& din_s != `DMIR_CMD_IDENT_FIRST);

endmodule : dmir_top

/* tb/dmir_host.sv */
/*
 Host model for the command port: strobes, select and the shared bus.
 Assumes the device answers within five sys_clk cycles.
*/
`timescale 1ns/100ps
module dmir_host (
	// Clock.
	input wire logic sys_clk,
	// Pins toward the device.
	output logic data_command_select,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [7:0] data_in,
	// Device drive of the bus.
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	logic [7:0] host_q;

	// A released bus shows the inverse of the last host byte.
	assign data_in = !data_oe_n ? data_out : host_q;

	initial begin
		data_command_select = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		host_q = 8'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask : hold

	task automatic wr(input logic dc, input logic [7:0] b);
		data_command_select = dc;
		host_q = b;
		write_strobe_n = 1'b0;
		hold(5);
		write_strobe_n = 1'b1;
		hold(5);
		host_q = ~host_q;
		hold(1);
	endtask : wr

	task automatic rd(output logic [7:0] v, output logic oe_n);
		data_command_select = 1'b1;
		read_strobe_n = 1'b0;
		hold(5);
		v = data_in;
		oe_n = data_oe_n;
		read_strobe_n = 1'b1;
		hold(5);
	endtask : rd

	task automatic unlock();
		wr(1'b0, 8'hff);
		wr(1'b1, 8'ha5);
	endtask : unlock
endmodule : dmir_host

/* tb/tb.sv */
/*
 Testbench for the identification readback block.
 Assumes the host model file is compiled before this one.
*/
`timescale 1ns/100ps
module tb;
	// Identification values are arbitrary.
	localparam logic [7:0] ID1 = 8'h5a;
	localparam logic [7:0] ID2 = 8'h6b;
	localparam logic [7:0] ID3 = 8'h7c;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic dcs, rsn, wsn, data_oe_n;
	logic [7:0] data_in, data_out, v;
	logic oe_n;
	logic [7:0] ids [3] = '{ID1, ID2, ID3};
	int n_mismatch = 0;
	int check_count = 0;

	always #50 sys_clk = ~sys_clk;

	dmir_host host (.sys_clk(sys_clk), .data_command_select(dcs),
		.read_strobe_n(rsn), .write_strobe_n(wsn), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n));

	dmir_top #(.IDENT_BYTE_FIRST(ID1), .IDENT_BYTE_SECOND(ID2),
		.IDENT_BYTE_THIRD(ID3)) uut (.sys_clk(sys_clk), .resetn(resetn),
		.data_command_select(dcs), .read_strobe_n(rsn),
		.write_strobe_n(wsn), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n));

	task automatic chk(input string what, input logic [8:0] exp,
		input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic id_seq(input int i);
		host.unlock();
		host.wr(1'b0, 8'hda + 8'(i));
		host.rd(v, oe_n);
		chk("dummy", 9'h000, {oe_n, v});
		host.rd(v, oe_n);
		chk("ident", {1'b0, ids[i]}, {oe_n, v});
		host.rd(v, oe_n);
		chk("third read", 9'h100, {oe_n, 8'h00});
	endtask : id_seq

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (8) @(posedge sys_clk);
		#10 resetn = 1'b1;
		host.hold(2);
		host.rd(v, oe_n);
		chk("idle read", 9'h100, {oe_n, 8'h00});
		for (int i = 0; i < 3; i++) id_seq(i);
		host.wr(1'b0, 8'h10);
		id_seq(0);
		host.wr(1'b0, 8'hda);
		host.wr(1'b0, 8'h3a);
		host.rd(v, oe_n);
		chk("other command", 9'h100, {oe_n, 8'h00});
		host.wr(1'b0, 8'hda);
		host.rd(v, oe_n);
		host.wr(1'b0, 8'hdb);
		host.rd(v, oe_n);
		chk("restart dummy", 9'h000, {oe_n, v});
		host.rd(v, oe_n);
		chk("restart ident", {1'b0, ID2}, {oe_n, v});
		host.wr(1'b0, 8'hdc);
		resetn = 1'b0;
		host.hold(3);
		resetn = 1'b1;
		host.hold(2);
		host.rd(v, oe_n);
		chk("read after reset", 9'h100, {oe_n, 8'h00});
		for (int i = 0; i < 3; i++) id_seq(i);
		tally_and_finish();
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : tb
